// ### rtl/sgc_pkg.sv
// Constants, types and register map of the sleep gating and reset cause controller.
// Assumes a single system clock; all users import the whole package.
// Behaviour
// - Sleep-enabled peripherals stay clocked during sleep
// - Sleep settings retained, inert while gating off
// - Gating off keeps every peripheral clocked
// - Clocked peripherals can wake the processor
// - Processor halted from sleep entry until wake
// - PWM clock divides processor clock by 1..64
// - Selected PWM ratio reads back as configured
// - Software reset resets all but cause store
// - Software reset keeps flags, adds software flag
// - Cause flags sticky until cleared or external reset
// - Six independent cause flags, read together
// - Clear touches only selected cause flags
// - SRAM size in bytes is readable
// - Optional pin presence is readable
package sgc_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SLEEP_EN = 8'h04;
	localparam logic [7:0] OFF_PWM_DIV = 8'h08;
	localparam logic [7:0] OFF_CAUSE = 8'h0c;
	localparam logic [7:0] OFF_SRAM = 8'h10;
	localparam logic [7:0] OFF_PIN_LO = 8'h14;
	localparam logic [7:0] OFF_PIN_HI = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_INT_STAT = 8'h20;
	localparam logic [7:0] OFF_INT_MASK = 8'h24;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_GATE_BIT = 0;
	localparam int CTRL_SWRST_BIT = 1;
	localparam int STAT_SLEEP_BIT = 0;
	localparam int INT_W = 2;
	localparam int INT_WAKE_BIT = 0;
	localparam int INT_SLEEP_BIT = 1;
	localparam int CAUSE_W = 6;
	localparam int CAUSE_EXT_BIT = 0;
	localparam int CAUSE_POR_BIT = 1;
	localparam int CAUSE_BOR_BIT = 2;
	localparam int CAUSE_WDOG_BIT = 3;
	localparam int CAUSE_SW_BIT = 4;
	localparam int CAUSE_LDO_BIT = 5;
	localparam int PIN_SLOW_CLOCK_BIT = 32;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic GATE_EN_RST = 1'b0;
	localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;

	// ----------------------------------------
	// Bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SW_RST_TIME_NS = 800;
	localparam int SW_RST_CYCLES = (SW_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		pwm_clock_ratio_1 = 3'h0,
		pwm_clock_ratio_2 = 3'h1,
		pwm_clock_ratio_4 = 3'h2,
		pwm_clock_ratio_8 = 3'h3,
		pwm_clock_ratio_16 = 3'h4,
		pwm_clock_ratio_32 = 3'h5,
		pwm_clock_ratio_64 = 3'h6
	} sgc_pwm_ratio_e;

	typedef enum logic {
		PWR_RUN = 1'b0,
		PWR_SLEEP = 1'b1
	} sgc_pwr_e;

endpackage : sgc_pkg

// ### rtl/sgc_sub_if.sv
// Carrier between the controller top and its two helpers.
// Assumes all three ends share one clock.
`timescale 1ns/1ns
interface sgc_sub_if;
	import sgc_pkg::*;
	logic [CAUSE_W-1:0] clr_mask;
	logic clr_stb;
	logic swrst_req;
	logic [CAUSE_W-1:0] flags;
	logic [2:0] div_code;
	logic pwm_tick;

	modport top_end(output clr_mask, clr_stb, swrst_req, div_code, input flags, pwm_tick);
	modport cause_end(input clr_mask, clr_stb, swrst_req, output flags);
	modport div_end(input div_code, output pwm_tick);
endinterface : sgc_sub_if

// ### rtl/sgc_pwm_div.sv
// PWM clock-enable divider: one tick every 2**code processor clocks.
// Assumes the code is already screened to the legal ratios.
`timescale 1ns/1ns
module sgc_pwm_div import sgc_pkg::*; #(
	parameter int CNT_W = 6
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Helper link
	sgc_sub_if.div_end sub
);

	initial begin
		if (CNT_W < 6) begin
			$error("sgc_pwm_div: CNT_W too small for ratio 64");
		end
	end

	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [2:0] code_q, code_d;
	logic tick_q, tick_d;
	logic [CNT_W:0] span;

	always_comb begin
		span = (CNT_W+1)'(1) << sub.div_code;
		code_d = sub.div_code;
		tick_d = 1'b0;
		if (code_q != sub.div_code) begin
			// Restart with a tick so no gap ever spans two ratios
			cnt_d = '0;
			tick_d = 1'b1;
		end else if (cnt_q == CNT_W'(span - 1'b1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_q <= '0;
			code_q <= 3'h0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			code_q <= code_d;
			tick_q <= tick_d;
		end
	end

	assign sub.pwm_tick = tick_q;

endmodule : sgc_pwm_div

// ### rtl/sgc_reset_cause.sv
// Sticky reset-cause store and software reset pulse generator.
// Assumes hw_rst_n comes only from power-on or the reset pin, never from the
// software reset this module drives out.
`timescale 1ns/1ns
module sgc_reset_cause import sgc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic hw_rst_n,
	input wire logic clk_en,
	// Asynchronous reset-source events
	input wire logic ext_rst_evt,
	input wire logic por_evt,
	input wire logic bor_evt,
	input wire logic wdog_evt,
	input wire logic ldo_evt,
	// Helper link
	sgc_sub_if.cause_end sub,
	// Device-wide software reset
	output logic sys_rst_n
);

	localparam int NSRC = 5;
	localparam logic [4:0] SW_RST_CNT = 5'(SW_RST_CYCLES);

	logic [NSRC-1:0] s1_q, s2_q, s3_q;
	logic [CAUSE_W-1:0] flags_q, flags_d, set_vec;
	logic [4:0] cnt_q, cnt_d;
	logic rst_n_q, rst_n_d;
	logic [NSRC-1:0] rise;

	always_comb begin
		rise = s2_q & ~s3_q;
		set_vec = '0;
		set_vec[CAUSE_EXT_BIT] = rise[0];
		set_vec[CAUSE_POR_BIT] = rise[1];
		set_vec[CAUSE_BOR_BIT] = rise[2];
		set_vec[CAUSE_WDOG_BIT] = rise[3];
		set_vec[CAUSE_LDO_BIT] = rise[4];
		cnt_d = cnt_q;
		if (cnt_q != 5'h0) begin
			cnt_d = cnt_q - 5'h1;
		end else if (sub.swrst_req) begin
			cnt_d = SW_RST_CNT;
			set_vec[CAUSE_SW_BIT] = 1'b1;
		end
		flags_d = flags_q;
		if (sub.clr_stb) begin
			flags_d = flags_q & ~sub.clr_mask;
		end
		// A new cause wins over a clear in the same cycle
		flags_d = flags_d | set_vec;
		if (rise[0]) begin
			flags_d = set_vec;
		end
		rst_n_d = (cnt_d == 5'h0);
	end

	always_ff @(posedge clock) begin
		if (!hw_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			flags_q <= CAUSE_RST;
			cnt_q <= 5'h0;
			rst_n_q <= 1'b1;
		end else if (clk_en) begin
			s1_q <= {ldo_evt, wdog_evt, bor_evt, por_evt, ext_rst_evt};
			s2_q <= s1_q;
			s3_q <= s2_q;
			flags_q <= flags_d;
			cnt_q <= cnt_d;
			rst_n_q <= rst_n_d;
		end
	end

	assign sub.flags = flags_q;
	assign sys_rst_n = rst_n_q;

endmodule : sgc_reset_cause

// ### rtl/sgc_ctrl.sv
// Top of the sleep clock gating and reset cause controller, AXI4-Lite slave.
// Assumes sys_rst_n is routed back into rst_n by the system; hw_rst_n only
// follows power-on and the reset pin.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module sgc_ctrl import sgc_pkg::*; #(
	parameter int NUM_PERIPH = 32,
	parameter logic [31:0] SRAM_BYTES = 32'h0000_4000,
	parameter logic [63:0] PIN_MASK = 64'h0000_0001_ffff_ffff
) (
	// Clock and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hw_rst_n,
	input wire logic clk_en,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Processor and peripherals
	input wire logic cpu_sleep_req,
	input wire logic [NUM_PERIPH-1:0] periph_wake_req,
	output logic cpu_halt,
	output logic [NUM_PERIPH-1:0] periph_clk_en,
	output logic pwm_clk_en,
	// Reset sources and software reset
	input wire logic ext_rst_evt,
	input wire logic por_evt,
	input wire logic bor_evt,
	input wire logic wdog_evt,
	input wire logic ldo_evt,
	output logic sys_rst_n,
	// Interrupt
	output logic irq
);

	initial begin
		if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin
			$error("sgc_ctrl: NUM_PERIPH must be 1..32");
		end
	end

	sgc_sub_if sub ();

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic gate_en_q, gate_en_d;
	logic [NUM_PERIPH-1:0] sleep_en_q, sleep_en_d;
	logic [2:0] div_code_q, div_code_d;
	logic [INT_W-1:0] int_stat_q, int_stat_d;
	logic [INT_W-1:0] int_mask_q, int_mask_d;
	logic irq_q, irq_d;
	sgc_pwr_e pwr_q, pwr_d;
	logic halt_q, halt_d;
	logic [NUM_PERIPH-1:0] pclk_q, pclk_d;
	logic pwm_q;
	logic swrst_q, swrst_d;
	logic clr_stb_q, clr_stb_d;
	logic [CAUSE_W-1:0] clr_mask_q, clr_mask_d;

	// AXI slave state
	logic aw_full_q, aw_full_d;
	logic w_full_q, w_full_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// ----------------------------------------
	// Per-peripheral sleep gate
	// ----------------------------------------
	logic [NUM_PERIPH-1:0] gate_keep;
	logic [NUM_PERIPH-1:0] wake_src;

	for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_gate
		// Gating only bites in sleep with the global switch on
		assign gate_keep[i] = (pwr_d == PWR_RUN) || !gate_en_q || sleep_en_q[i];
		// A gated peripheral has no clock, so its request is void
		assign wake_src[i] = periph_wake_req[i] && pclk_q[i];
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	sgc_reset_cause u_cause (
		.clock(clock),
		.hw_rst_n(hw_rst_n),
		.clk_en(clk_en),
		.ext_rst_evt(ext_rst_evt),
		.por_evt(por_evt),
		.bor_evt(bor_evt),
		.wdog_evt(wdog_evt),
		.ldo_evt(ldo_evt),
		.sub(sub.cause_end),
		.sys_rst_n(sys_rst_n)
	);

	sgc_pwm_div #(.CNT_W(6)) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.sub(sub.div_end)
	);

	assign sub.clr_mask = clr_mask_q;
	assign sub.clr_stb = clr_stb_q;
	assign sub.swrst_req = swrst_q;
	assign sub.div_code = div_code_q;

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	function automatic logic [32:0] read_reg(input logic [ADDR_W-1:0] addr);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		unique case (addr)
			OFF_CTRL: r[CTRL_GATE_BIT] = gate_en_q;
			OFF_SLEEP_EN: r[NUM_PERIPH-1:0] = sleep_en_q;
			OFF_PWM_DIV: r[2:0] = div_code_q;
			OFF_CAUSE: r[CAUSE_W-1:0] = sub.flags;
			OFF_SRAM: r[31:0] = SRAM_BYTES;
			OFF_PIN_LO: r[31:0] = PIN_MASK[31:0];
			OFF_PIN_HI: r[31:0] = PIN_MASK[63:32];
			OFF_STATUS: r[STAT_SLEEP_BIT] = halt_q;
			OFF_INT_STAT: r[INT_W-1:0] = int_stat_q;
			OFF_INT_MASK: r[INT_W-1:0] = int_mask_q;
			default: r[32] = 1'b0;
		endcase
		return r;
	endfunction : read_reg

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	logic do_wr;
	logic do_rd;
	logic [31:0] wmask;
	logic [31:0] wnew;
	logic [32:0] rd;
	logic [INT_W-1:0] int_set;
	logic wake;

	always_comb begin
		gate_en_d = gate_en_q;
		sleep_en_d = sleep_en_q;
		div_code_d = div_code_q;
		int_mask_d = int_mask_q;
		swrst_d = 1'b0;
		clr_stb_d = 1'b0;
		clr_mask_d = clr_mask_q;
		int_set = '0;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		wmask = '0;
		wnew = '0;
		rd = '0;

		// Address and data are taken independently, in either order
		if (s_axi_awvalid && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end

		do_wr = aw_full_q && w_full_q && !bvalid_q;
		if (do_wr) begin
			wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (awaddr_q)
				OFF_CTRL: begin
					wnew = ({31'h0, gate_en_q} & ~wmask) | (wdata_q & wmask);
					gate_en_d = wnew[CTRL_GATE_BIT];
					swrst_d = wnew[CTRL_SWRST_BIT];
				end
				OFF_SLEEP_EN: begin
					wnew = (32'(sleep_en_q) & ~wmask) | (wdata_q & wmask);
					sleep_en_d = wnew[NUM_PERIPH-1:0];
				end
				OFF_PWM_DIV: begin
					// Codes past the largest ratio are dropped, keeping the last one
					if (wstrb_q[0] && wdata_q[2:0] <= pwm_clock_ratio_64) begin
						div_code_d = wdata_q[2:0];
					end
				end
				OFF_CAUSE: begin
					clr_stb_d = 1'b1;
					clr_mask_d = wdata_q[CAUSE_W-1:0] & wmask[CAUSE_W-1:0];
				end
				OFF_INT_MASK: begin
					wnew = (32'(int_mask_q) & ~wmask) | (wdata_q & wmask);
					int_mask_d = wnew[INT_W-1:0];
				end
				OFF_SRAM, OFF_PIN_LO, OFF_PIN_HI, OFF_STATUS, OFF_INT_STAT: begin
					bresp_d = RESP_OKAY;
				end
				default: bresp_d = RESP_SLVERR;
			endcase
		end

		do_rd = s_axi_arvalid && arready_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (do_rd) begin
			rd = read_reg(s_axi_araddr);
			rvalid_d = 1'b1;
			rdata_d = rd[31:0];
			rresp_d = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end

		// Sleep sequencing
		wake = |wake_src;
		pwr_d = pwr_q;
		unique case (pwr_q)
			PWR_RUN: begin
				if (cpu_sleep_req) begin
					pwr_d = PWR_SLEEP;
					int_set[INT_SLEEP_BIT] = 1'b1;
				end
			end
			PWR_SLEEP: begin
				if (wake) begin
					pwr_d = PWR_RUN;
					int_set[INT_WAKE_BIT] = 1'b1;
				end
			end
		endcase
		halt_d = (pwr_d == PWR_SLEEP);
		pclk_d = gate_keep;

		// Read clears the sticky bits, a same-cycle event survives
		int_stat_d = int_stat_q;
		if (do_rd && s_axi_araddr == OFF_INT_STAT) begin
			int_stat_d = '0;
		end
		int_stat_d = int_stat_d | int_set;
		irq_d = |(int_stat_d & int_mask_d);

		// One write and one read at a time
		awready_d = !aw_full_d && !bvalid_d;
		wready_d = !w_full_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gate_en_q <= GATE_EN_RST;
			sleep_en_q <= '0;
			div_code_q <= pwm_clock_ratio_1;
			int_stat_q <= '0;
			int_mask_q <= INT_MASK_RST;
			irq_q <= 1'b0;
			pwr_q <= PWR_RUN;
			halt_q <= 1'b0;
			pclk_q <= '1;
			pwm_q <= 1'b0;
			swrst_q <= 1'b0;
			clr_stb_q <= 1'b0;
			clr_mask_q <= '0;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (clk_en) begin
			gate_en_q <= gate_en_d;
			sleep_en_q <= sleep_en_d;
			div_code_q <= div_code_d;
			int_stat_q <= int_stat_d;
			int_mask_q <= int_mask_d;
			irq_q <= irq_d;
			pwr_q <= pwr_d;
			halt_q <= halt_d;
			pclk_q <= pclk_d;
			pwm_q <= sub.pwm_tick;
			swrst_q <= swrst_d;
			clr_stb_q <= clr_stb_d;
			clr_mask_q <= clr_mask_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign cpu_halt = halt_q;
	assign periph_clk_en = pclk_q;
	assign pwm_clk_en = pwm_q;
	assign irq = irq_q;

endmodule : sgc_ctrl

// ### verif/sgc_ctrl_monitor.sv
// Concurrent checks on the sleep gating and reset cause controller.
// Assumes it is bound into sgc_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module sgc_ctrl_monitor import sgc_pkg::*; #(
	parameter int NUM_PERIPH = 32
) (
	// Clock and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hw_rst_n,
	input wire logic clk_en,
	// Processor and peripherals
	input wire logic cpu_sleep_req,
	input wire logic [NUM_PERIPH-1:0] periph_wake_req,
	input wire logic cpu_halt,
	input wire logic [NUM_PERIPH-1:0] periph_clk_en,
	input wire logic pwm_clk_en,
	// Software reset
	input wire logic sys_rst_n
);
	// --------
	// Counters
	// --------
	logic [7:0] low_q, low_d, gap_q, gap_d;
	always_comb begin
		low_d = sys_rst_n ? 8'h00 : low_q + {7'h00, clk_en};
		gap_d = pwm_clk_en ? 8'h00 : gap_q + {7'h00, clk_en};
	end
	always_ff @(posedge clock) begin
		low_q <= hw_rst_n ? low_d : 8'h00;
		gap_q <= rst_n ? gap_d : 8'h00;
	end
	// --------
	// Checks
	// --------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_sleep;
		!cpu_halt && cpu_sleep_req && clk_en;
	endsequence
	sequence s_wake;
		cpu_halt && clk_en && (|(periph_wake_req & periph_clk_en));
	endsequence
	sleep_entry_a: assert property (s_sleep |=> cpu_halt)
		else $error("sleep request did not halt");
	halt_cause_a: assert property ($rose(cpu_halt) |-> $past(cpu_sleep_req))
		else $error("halt without sleep request");
	halt_hold_a: assert property (cpu_halt && !(|(periph_wake_req & periph_clk_en)) |=> cpu_halt)
		else $error("halt left without wake");
	wake_exit_a: assert property (s_wake |=> !cpu_halt && (&periph_clk_en))
		else $error("wake did not resume run");
	run_clocks_a: assert property (!cpu_halt |-> &periph_clk_en)
		else $error("clock gated while running");
	sleep_stable_a: assert property (cpu_halt && $past(cpu_halt) |-> $stable(periph_clk_en))
		else $error("clock gating changed during sleep");
	swrst_len_a: assert property (@(posedge clock) disable iff (!hw_rst_n)
		$rose(sys_rst_n) |-> low_q == 8'h10) else $error("software reset length wrong");
	pwm_gap_a: assert property (gap_q <= 8'h3f)
		else $error("pwm tick gap above 64");
endmodule : sgc_ctrl_monitor

bind sgc_ctrl sgc_ctrl_monitor #(.NUM_PERIPH(NUM_PERIPH)) mon_u (
	.clock(clock), .rst_n(rst_n), .hw_rst_n(hw_rst_n), .clk_en(clk_en),
	.cpu_sleep_req(cpu_sleep_req), .periph_wake_req(periph_wake_req), .cpu_halt(cpu_halt),
	.periph_clk_en(periph_clk_en), .pwm_clk_en(pwm_clk_en), .sys_rst_n(sys_rst_n)
);

// ### verif/testbench.sv
// Self-checking bench for the sleep gating and reset cause controller.
// Assumes sys_rst_n loops back into rst_n as in the system; clk_en stays high.
`timescale 1ns/1ns
module testbench import sgc_pkg::*; ();
	localparam logic [31:0] SRAM_SZ = 32'h0000_8000;
	localparam logic [63:0] PINS = 64'h0000_0001_0f0f_00ff;
	logic clock = 1'b0;
	logic tb_rst_n, hw_rst_n, awvalid, wvalid, bready, arvalid, rready, sleep_req;
	logic awready, wready, bvalid, arready, rvalid, halt, pwm_tick, sys_rst_n, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, wake_req, clk_on;
	logic [1:0] bresp, rresp;
	logic [4:0] evt;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire rst_n = tb_rst_n & sys_rst_n;

	sgc_ctrl #(.SRAM_BYTES(SRAM_SZ), .PIN_MASK(PINS)) dut_u (
		.clock(clock), .rst_n(rst_n), .hw_rst_n(hw_rst_n), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cpu_sleep_req(sleep_req), .periph_wake_req(wake_req), .cpu_halt(halt),
		.periph_clk_en(clk_on), .pwm_clk_en(pwm_tick), .ext_rst_evt(evt[0]), .por_evt(evt[1]),
		.bor_evt(evt[2]), .wdog_evt(evt[3]), .ldo_evt(evt[4]), .sys_rst_n(sys_rst_n), .irq(irq)
	);

	always #25 clock = ~clock;

	// --------
	// Checking
	// --------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// Responses are compared against notes left by the bus tasks
	always @(posedge clock) begin
		cyc++;
		if (bvalid && bready) chk(bresp, bq.pop_front());
		if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
		if (cyc > 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	// --------
	// Drivers
	// --------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit done = 0;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit done = 0;
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask : rd

	task automatic poke(input logic s, input logic [31:0] w);
		sleep_req <= s;
		wake_req <= w;
		@(posedge clock);
		sleep_req <= 1'b0;
		wake_req <= 32'h0;
		@(posedge clock);
	endtask : poke

	task automatic ev(input logic [4:0] v);
		evt <= v;
		repeat (4) @(posedge clock);
		evt <= 5'h00;
		repeat (4) @(posedge clock);
	endtask : ev

	// First gaps after a ratio change are skipped
	task automatic gap(input int code);
		int n = 0;
		repeat (3) begin
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (!pwm_tick && n < 200);
		end
		chk(n, 1 << code);
	endtask : gap

	initial begin
		logic [31:0] m;
		int k;
		{tb_rst_n, hw_rst_n, awvalid, wvalid, bready, arvalid, rready, sleep_req} = 8'h00;
		{awaddr, araddr, wdata, wake_req, evt} = '0;
		m = $urandom(32'h0455);
		repeat (2) @(posedge clock);
		tb_rst_n <= 1'b1;
		hw_rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(OFF_PWM_DIV, 32'h0, RESP_OKAY);
		rd(OFF_SLEEP_EN, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		rd(OFF_CAUSE, 32'h0, RESP_OKAY);
		wr(OFF_SRAM, m, RESP_OKAY);
		rd(OFF_SRAM, SRAM_SZ, RESP_OKAY);
		rd(OFF_PIN_LO, PINS[31:0], RESP_OKAY);
		rd(OFF_PIN_HI, PINS[63:32], RESP_OKAY);
		wr(8'h28, m, RESP_SLVERR);
		rd(8'h28, 32'h0, RESP_SLVERR);
		for (int c = 0; c < 7; c++) begin
			wr(OFF_PWM_DIV, 32'(c), RESP_OKAY);
			rd(OFF_PWM_DIV, 32'(c), RESP_OKAY);
			gap(c);
		end
		wr(OFF_PWM_DIV, 32'h7, RESP_OKAY);
		rd(OFF_PWM_DIV, 32'h6, RESP_OKAY);
		// Peripheral 0 kept, peripheral 1 gated in sleep
		m = ($urandom() | 32'h1) & ~32'h2;
		wr(OFF_SLEEP_EN, m, RESP_OKAY);
		wr(OFF_INT_MASK, 32'h3, RESP_OKAY);
		poke(1'b1, 32'h0);
		chk(halt, 1'b1);
		chk(clk_on, 32'hffff_ffff);
		poke(1'b0, 32'h2);
		chk(halt, 1'b0);
		repeat (2) @(posedge clock);
		chk(irq, 1'b1);
		rd(OFF_INT_STAT, 32'h3, RESP_OKAY);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		rd(OFF_SLEEP_EN, m, RESP_OKAY);
		wr(OFF_INT_MASK, 32'h0, RESP_OKAY);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		poke(1'b1, 32'h0);
		chk(clk_on, m);
		rd(OFF_STATUS, 32'h1, RESP_OKAY);
		poke(1'b0, 32'h2);
		chk(halt, 1'b1);
		poke(1'b0, 32'h1);
		chk(halt, 1'b0);
		chk(clk_on, 32'hffff_ffff);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		rd(OFF_INT_STAT, 32'h3, RESP_OKAY);
		ev(5'b01100);
		rd(OFF_CAUSE, 32'h0c, RESP_OKAY);
		wr(OFF_CAUSE, 32'h04, RESP_OKAY);
		repeat (3) @(posedge clock);
		rd(OFF_CAUSE, 32'h08, RESP_OKAY);
		wr(OFF_PWM_DIV, 32'h3, RESP_OKAY);
		wr(OFF_CTRL, 32'h3, RESP_OKAY);
		k = 0;
		while (sys_rst_n && k < 50) begin
			@(posedge clock);
			k++;
		end
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (!sys_rst_n && k < 50);
		chk(k, 16);
		repeat (2) @(posedge clock);
		rd(OFF_CAUSE, 32'h18, RESP_OKAY);
		rd(OFF_PWM_DIV, 32'h0, RESP_OKAY);
		rd(OFF_SLEEP_EN, 32'h0, RESP_OKAY);
		rd(OFF_CTRL, 32'h0, RESP_OKAY);
		ev(5'b00001);
		rd(OFF_CAUSE, 32'h01, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			wr(OFF_CAUSE, 32'h3f, RESP_OKAY);
			repeat (3) @(posedge clock);
			ev(5'(1 << i));
			rd(OFF_CAUSE, 32'(1 << (i == 4 ? CAUSE_LDO_BIT : i)), RESP_OKAY);
		end
		hw_rst_n <= 1'b0;
		tb_rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		hw_rst_n <= 1'b1;
		tb_rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(OFF_CAUSE, 32'h0, RESP_OKAY);
		conclude();
	end
endmodule : testbench
